// >>> i2cmte.sv
// i2c master transaction engine: transmit fifo and bus sequencer
//
// Behaviour
// - enabled, empty data and interrupt enable give transmit interrupt
// - start request with address waiting: start condition, load shifter
// - transmit interrupt again after first address bit leaves
// - slave pulling sda low in ack high phase sets ack status
// - nack without pending stop/start sets nack flag, clears ack
// - after stop following nack, clear stop bit and nack flag
// - each data byte reloads shifter, shifts, interrupt after first bit
// - pending stop/start at final byte suppresses nack event
// - after final byte emit stop or restart; stop clears its request, restart leaves start pending until next start
// - stop bit clears when address-only transaction finishes
// - after probe ack status shows whether slave acknowledged
// - probe never raises nack event since stop is pending
// - after first 10-bit byte acked, load and send second byte
// - start waits for both start request and written data
// - empty data while sending, no stop/start pending: stall before ack cycle
// - flush with stop or start discards stale data
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////
module i2cmte_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  // fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // drain side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready,
  // discard all words
  input  wire logic         flush
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(D);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_idx;
  logic [AW-1:0] rd_idx;
  logic [AW:0]   count;
  logic [AW:0]   next_count;
  wire           push = in_valid & in_ready;
  wire           pop  = out_valid & out_ready;

  assign out_data = mem[rd_idx];

  always_comb begin
    next_count = count;
    if (flush) begin
      next_count = '0;
    end else if (push & ~pop) begin
      next_count = count + 1'b1;
    end else if (pop & ~push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_idx] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wr_idx    <= '0;
      rd_idx    <= '0;
      count     <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      wr_idx    <= flush ? '0 : (push ? wr_idx + 1'b1 : wr_idx);
      rd_idx    <= flush ? '0 : (pop ? rd_idx + 1'b1 : rd_idx);
      count     <= next_count;
      in_ready  <= next_count != FULL_CNT;
      out_valid <= next_count != '0;
    end
  end
endmodule : i2cmte_fifo

////////////////////////////////////////////////////////////////////////////
`include "i2cmte_regs.svh"
module i2cmte (
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          rst_b,
  // control levels
  input  wire logic                          controller_enable,
  input  wire logic                          transmit_interrupt_enable,
  // control request pulse
  input  wire logic                          ctl_write,
  input  wire i2cmte_pkg::i2cmte_ctl_s       ctl_bits,
  // transmit data stream
  input  wire logic                          wr_valid,
  input  wire logic [`I2CMTE_BYTE_W-1:0]     wr_data,
  output logic                               wr_ready,
  // status
  output i2cmte_pkg::i2cmte_sts_s            status,
  output logic                               tx_irq,
  // bus pins
  input  wire logic                          scl_in,
  output logic                               scl_out,
  output logic                               scl_oe,
  input  wire logic                          sda_in,
  output logic                               sda_out,
  output logic                               sda_oe
);
  import i2cmte_pkg::*;

  localparam logic [`I2CMTE_QCNT_W-1:0] QTR_LAST =
    `I2CMTE_QCNT_W'(`I2CMTE_QTR_CYC - 1);

  i2cmte_state_e               state;
  logic [1:0]                  ph;
  logic [`I2CMTE_QCNT_W-1:0]   qcnt;
  logic [3:0]                  bit_cnt;
  logic [`I2CMTE_BYTE_W-1:0]   shreg;
  logic                        scl_meta;
  logic                        scl_s;
  logic                        sda_meta;
  logic                        sda_s;
  logic                        start_pend;
  logic                        stop_pend;
  logic                        nack_flag;
  logic                        ack_bit;
  logic                        fifo_valid;
  logic [`I2CMTE_BYTE_W-1:0]   fifo_data;

  ////////////////////////////////////////////////////////////////////////
  // decode
  wire st_idle  = state == I2CMTE_IDLE;
  wire st_start = state == I2CMTE_START;
  wire st_bit   = state == I2CMTE_BIT;
  wire st_wait  = state == I2CMTE_ACKWAIT;
  wire st_nak   = state == I2CMTE_NAKHOLD;
  wire st_stop  = state == I2CMTE_STOP;
  wire st_rst   = state == I2CMTE_RESTART;
  wire timed    = st_start | st_bit | st_stop | st_rst;
  wire tick     = qcnt == QTR_LAST;
  wire stretch  = (ph == 2'h2) & ~scl_s;
  wire step     = timed & tick & ~stretch;
  wire ph_end   = step & (ph == 2'h3);
  wire in_ack   = bit_cnt == `I2CMTE_ACK_SLOT;
  wire pend_any = stop_pend | start_pend;
  wire set_start = ctl_write & ctl_bits.start;
  wire set_stop  = ctl_write & ctl_bits.stop;
  wire do_flush  = ctl_write & ctl_bits.flush & (ctl_bits.start | ctl_bits.stop);
  wire go_start  = st_idle & controller_enable & start_pend & fifo_valid;
  wire start_end = st_start & ph_end;
  wire data_end  = st_bit & ph_end & ~in_ack;
  wire last_data = data_end & (bit_cnt == 4'h7);
  wire ack_end   = st_bit & ph_end & in_ack;
  wire nack_evt  = ack_end & sda_s & ~pend_any;
  wire stop_end  = st_stop & ph_end;
  wire rst_end   = st_rst & ph_end;
  // pop after first bit, exposing empty
  wire pop       = st_bit & ph_end & (bit_cnt == 4'h0) & fifo_valid;
  wire hold_sda  = (st_bit | st_stop | st_rst) & (ph == 2'h0);
  wire scl_low   = (st_bit | st_stop | st_rst) & ~ph[1] | st_wait | st_nak;
  wire sda_low   = st_bit & ~in_ack & ~shreg[`I2CMTE_MSB]
                 | st_start & ph[1]
                 | st_stop & (ph != 2'h3);

  ////////////////////////////////////////////////////////////////////////
  // transmit fifo
  i2cmte_fifo #(
    .W (`I2CMTE_BYTE_W),
    .D (`I2CMTE_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .in_valid  (wr_valid),
    .in_data   (wr_data),
    .in_ready  (wr_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (pop),
    .flush     (do_flush)
  );

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      scl_meta <= 1'b1;
      scl_s    <= 1'b1;
      sda_meta <= 1'b1;
      sda_s    <= 1'b1;
    end else begin
      scl_meta <= scl_in;
      scl_s    <= scl_meta;
      sda_meta <= sda_in;
      sda_s    <= sda_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // quarter bit timing
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      qcnt <= '0;
      ph   <= 2'h0;
    end else if (!timed || step) begin
      qcnt <= '0;
      ph   <= timed ? ph + 2'h1 : 2'h0;
    end else if (!tick) begin
      qcnt <= qcnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state   <= I2CMTE_IDLE;
      bit_cnt <= 4'h0;
      shreg   <= '0;
    end else if (!controller_enable) begin
      state   <= I2CMTE_IDLE;
      bit_cnt <= 4'h0;
    end else begin
      case (state)
        I2CMTE_IDLE: begin
          if (go_start) begin
            state <= I2CMTE_START;
          end
        end
        I2CMTE_START: begin
          if (start_end) begin
            state   <= I2CMTE_BIT;
            shreg   <= fifo_data;
            bit_cnt <= 4'h0;
          end
        end
        I2CMTE_BIT: begin
          if (data_end) begin
            shreg   <= {shreg[`I2CMTE_MSB-1:0], 1'b0};
            bit_cnt <= bit_cnt + 4'h1;
            if (last_data && !fifo_valid && !pend_any) begin
              state <= I2CMTE_ACKWAIT;
            end
          end else if (ack_end) begin
            bit_cnt <= 4'h0;
            if (nack_evt) begin
              state <= I2CMTE_NAKHOLD;
            // stop or restart after last byte
            end else if (stop_pend) begin
              state <= I2CMTE_STOP;
            end else if (start_pend) begin
              state <= I2CMTE_RESTART;
            end else begin
              shreg <= fifo_data;
            end
          end
        end
        I2CMTE_ACKWAIT: begin
          if (fifo_valid || pend_any) begin
            state <= I2CMTE_BIT;
          end
        end
        I2CMTE_NAKHOLD: begin
          if (stop_pend) begin
            state <= I2CMTE_STOP;
          end else if (start_pend) begin
            state <= I2CMTE_RESTART;
          end
        end
        I2CMTE_STOP: begin
          if (stop_end) begin
            state <= I2CMTE_IDLE;
          end
        end
        I2CMTE_RESTART: begin
          // released lines then start again from idle
          if (rst_end) begin
            state <= I2CMTE_IDLE;
          end
        end
        default: begin
          state <= I2CMTE_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // request and status flags, set wins over clear
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      start_pend <= 1'b0;
      stop_pend  <= 1'b0;
      nack_flag  <= 1'b0;
      ack_bit    <= 1'b0;
    end else begin
      start_pend <= set_start | (start_pend & ~start_end);
      stop_pend  <= set_stop | (stop_pend & ~stop_end);
      nack_flag  <= nack_evt | (nack_flag & ~(stop_end | rst_end));
      if (ack_end) begin
        ack_bit <= ~sda_s;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      status  <= '0;
      tx_irq  <= 1'b0;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe  <= 1'b0;
      sda_oe  <= 1'b0;
    end else begin
      status.transmit_data_empty  <= ~fifo_valid;
      status.ack                  <= ack_bit;
      status.not_acknowledge_flag <= nack_flag;
      status.start_pending        <= start_pend;
      status.stop_pending         <= stop_pend;
      status.busy                 <= ~st_idle;
      tx_irq  <= controller_enable & transmit_interrupt_enable & ~fifo_valid;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe  <= scl_low;
      sda_oe  <= hold_sda ? sda_oe : sda_low;
    end
  end
endmodule : i2cmte

// >>> i2cmte_pkg.sv
// types of the i2c master transaction engine
package i2cmte_pkg;
  typedef enum logic [6:0] {
    I2CMTE_IDLE    = 7'h01,
    I2CMTE_START   = 7'h02,
    I2CMTE_BIT     = 7'h04,
    I2CMTE_ACKWAIT = 7'h08,
    I2CMTE_NAKHOLD = 7'h10,
    I2CMTE_STOP    = 7'h20,
    I2CMTE_RESTART = 7'h40
  } i2cmte_state_e;
  typedef struct packed {
    logic start;
    logic stop;
    logic flush;
  } i2cmte_ctl_s;
  typedef struct packed {
    logic transmit_data_empty;
    logic ack;
    logic not_acknowledge_flag;
    logic start_pending;
    logic stop_pending;
    logic busy;
  } i2cmte_sts_s;
endpackage : i2cmte_pkg

// >>> i2cmte_props.sv
// port property checker of the i2c master transaction engine
`timescale 1ns/1ns
module i2cmte_props (
  // clock and reset
  input wire logic                    clk_sys,
  input wire logic                    rst_b,
  // control levels
  input wire logic                    controller_enable,
  input wire logic                    transmit_interrupt_enable,
  // observed outputs and pins
  input wire i2cmte_pkg::i2cmte_sts_s status,
  input wire logic                    tx_irq,
  input wire logic                    scl_out,
  input wire logic                    scl_oe,
  input wire logic                    sda_in,
  input wire logic                    sda_out,
  input wire logic                    sda_oe
);
  import i2cmte_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // sda pulled or freed while scl is released high
  sequence s_sda_pull;
    $rose(sda_oe) && !scl_oe;
  endsequence
  sequence s_sda_free;
    $fell(sda_oe) && !scl_oe && controller_enable;
  endsequence
  chk_irq_level: assert property (
    tx_irq == ($past(controller_enable) && status.transmit_data_empty
    && $past(transmit_interrupt_enable))) else $error("irq level wrong");
  chk_open_drain: assert property (
    !scl_out && !sda_out) else $error("pin driven high");
  chk_start_cond: assert property (s_sda_pull |->
    status.start_pending && !status.transmit_data_empty)
    else $error("start without request and data");
  chk_stop_cond: assert property (s_sda_free |->
    status.stop_pending || status.start_pending)
    else $error("stop without request");
  chk_ack_sample: assert property ($rose(status.ack) |->
    !$past(scl_oe, 4) && !$past(sda_in, 4)) else $error("ack unfounded");
  chk_nack_event: assert property (
    $rose(status.not_acknowledge_flag) |-> !status.ack
    && !$past(status.stop_pending) && !$past(status.start_pending))
    else $error("nack event wrong");
  chk_stop_clear: assert property ($fell(status.stop_pending) |->
    !sda_oe && !scl_oe ##[0:8] !status.not_acknowledge_flag)
    else $error("stop clear wrong");
  chk_idle_free: assert property (!controller_enable [*3] |->
    !scl_oe && !sda_oe) else $error("lines held while disabled");
endmodule : i2cmte_props

bind i2cmte i2cmte_props i_props (.clk_sys, .rst_b, .controller_enable,
  .transmit_interrupt_enable, .status, .tx_irq, .scl_out, .scl_oe,
  .sda_in, .sda_out, .sda_oe);

// >>> i2cmte_regs.svh
// timing and field constants of the i2c master transaction engine
`ifndef I2CMTE_REGS_SVH
`define I2CMTE_REGS_SVH
`define I2CMTE_CLK_PERIOD_NS 8
`define I2CMTE_SCL_PERIOD_NS 2500
`define I2CMTE_QTR_CYC (`I2CMTE_SCL_PERIOD_NS / (4 * `I2CMTE_CLK_PERIOD_NS))
`define I2CMTE_QCNT_W 9
`define I2CMTE_BYTE_W 8
`define I2CMTE_FIFO_DEPTH 16
`define I2CMTE_ACK_SLOT 4'h8
`define I2CMTE_MSB 7
`endif

// >>> i2cmte_slave.sv
// behavioural i2c slave that captures bytes and acknowledges on demand
`timescale 1ns/1ns
module i2cmte_slave (
  // wired bus
  input  wire logic  scl,
  input  wire logic  sda,
  output logic       sda_oe,
  // control and capture
  input  wire logic  ack_en,
  output logic [7:0] rx_byte
);
  int         cnt;
  logic [7:0] sh;
  initial begin
    sda_oe  = 1'b0;
    rx_byte = 8'h00;
    sh      = 8'h00;
    cnt     = 0;
  end
  always @(negedge sda) begin
    if (scl) begin
      cnt = 0;
    end
  end
  always @(posedge scl) begin
    if (cnt < 8) begin
      sh = {sh[6:0], sda};
    end
    cnt = cnt + 1;
  end
  always @(negedge scl) begin
    if (cnt == 8) begin
      sda_oe  = ack_en;
      rx_byte = sh;
    end else if (cnt == 9) begin
      sda_oe = 1'b0;
      cnt    = 0;
    end
  end
endmodule : i2cmte_slave

// >>> tb_top.sv
// self-checking bench of the i2c master transaction engine
`timescale 1ns/1ns
module tb_top;
  import i2cmte_pkg::*;
  logic        clk_sys, rst_b, controller_enable, transmit_interrupt_enable;
  logic        ctl_write, wr_valid, wr_ready, tx_irq, ack_en, slv_oe;
  logic        scl_out, scl_oe, sda_out, sda_oe;
  logic [7:0]  wr_data, rx_byte;
  i2cmte_ctl_s ctl_bits;
  i2cmte_sts_s status;
  wire         scl = ~scl_oe;
  wire         sda = ~(sda_oe | slv_oe);
  int          err_count, cmp_count;

  i2cmte i_dut (.clk_sys, .rst_b, .controller_enable,
    .transmit_interrupt_enable, .ctl_write, .ctl_bits, .wr_valid,
    .wr_data, .wr_ready, .status, .tx_irq, .scl_in(scl), .scl_out,
    .scl_oe, .sda_in(sda), .sda_out, .sda_oe);
  i2cmte_slave i_slave (.scl, .sda, .sda_oe(slv_oe), .ack_en, .rx_byte);

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [7:0] e, g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chb(input string nm, input logic e, g);
    chk(nm, {7'h00, e}, {7'h00, g});
  endtask : chb
  task automatic ctl(input logic s, p, f, t);
    @(posedge clk_sys);
    ctl_write                 <= 1'b1;
    ctl_bits                  <= {s, p, f};
    transmit_interrupt_enable <= t;
    @(posedge clk_sys);
    ctl_write <= 1'b0;
  endtask : ctl
  task automatic push(input logic [7:0] b);
    @(posedge clk_sys);
    wr_valid <= 1'b1;
    wr_data  <= b;
    @(posedge clk_sys);
    while (wr_ready !== 1'b1) @(posedge clk_sys);
    wr_valid <= 1'b0;
  endtask : push
  function automatic logic hit(input int k);
    case (k)
      0: return tx_irq === 1'b1;
      1: return status.stop_pending === 1'b0;
      default: return status.not_acknowledge_flag === 1'b1;
    endcase
  endfunction : hit
  // bounded wait: 0 irq, 1 stop done, 2 nack flag
  task automatic wt(input int k);
    int i;
    repeat (4) @(posedge clk_sys);
    for (i = 0; i < 30000 && !hit(k); i++) @(posedge clk_sys);
    chb("wait", 1'b1, hit(k));
  endtask : wt
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    repeat (4) @(posedge clk_sys);
    controller_enable         <= 1'b1;
    transmit_interrupt_enable <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chb("empty", 1'b1, status.transmit_data_empty);
    chb("irq", 1'b1, tx_irq);
    transmit_interrupt_enable <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chb("irq_off", 1'b0, tx_irq);
    $display("test reset done");
  endtask : t_reset
  task automatic t_probe(input logic [7:0] a, input logic k);
    ack_en <= k;
    push(a);
    ctl(1'b1, 1'b1, 1'b0, 1'b0);
    wt(1);
    chb("ack", k, status.ack);
    chb("nack", 1'b0, status.not_acknowledge_flag);
    chk("addr", a, rx_byte);
    chb("scl_free", 1'b1, scl);
    $display("test probe done");
  endtask : t_probe
  task automatic t_write(input logic [7:0] a, d);
    ack_en <= 1'b1;
    push(a);
    ctl(1'b1, 1'b0, 1'b0, 1'b1);
    wt(0);
    chb("busy", 1'b1, status.busy);
    push(d);
    wt(0);
    ctl(1'b0, 1'b1, 1'b0, 1'b0);
    wt(1);
    chb("ack", 1'b1, status.ack);
    chb("nack", 1'b0, status.not_acknowledge_flag);
    chk("data", d, rx_byte);
    $display("test write done");
  endtask : t_write
  task automatic t_probe10(input logic [7:0] a1, a2);
    ack_en <= 1'b1;
    push(a1);
    ctl(1'b1, 1'b0, 1'b0, 1'b1);
    wt(0);
    push(a2);
    wt(0);
    ctl(1'b0, 1'b1, 1'b0, 1'b0);
    wt(1);
    chb("ack", 1'b1, status.ack);
    chb("nack", 1'b0, status.not_acknowledge_flag);
    chk("addr2", a2, rx_byte);
    $display("test probe10 done");
  endtask : t_probe10
  task automatic t_nack(input logic [7:0] a, d);
    ack_en <= 1'b0;
    push(a);
    ctl(1'b1, 1'b0, 1'b0, 1'b1);
    wt(0);
    push(d);
    wt(2);
    chb("ack", 1'b0, status.ack);
    chb("stale", 1'b0, status.transmit_data_empty);
    ctl(1'b0, 1'b1, 1'b1, 1'b0);
    wt(1);
    chb("nack", 1'b0, status.not_acknowledge_flag);
    chb("flushed", 1'b1, status.transmit_data_empty);
    controller_enable <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chb("sda_free", 1'b1, sda);
    $display("test nack done");
  endtask : t_nack
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge clk_sys);
    err_count++;
    $display("[ERR] watchdog expected done seen hang");
    summarize();
  end
  initial begin
    {rst_b, controller_enable, transmit_interrupt_enable} = 3'h0;
    {ctl_write, wr_valid, ack_en} = 3'h0;
    ctl_bits = '0;
    wr_data  = 8'h00;
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_reset();
    t_probe(8'hA0, 1'b0);
    t_probe(8'hA1, 1'b1);
    t_write(8'hA0, 8'h5C);
    t_probe10(8'hF0, 8'h5A);
    t_nack(8'h42, 8'h3C);
    summarize();
  end
endmodule : tb_top
